// ===== tb/cim_monitor_status_assertions.sv
// port checker for the clock monitor status bank
`timescale 1ns/10ps
module cim_monitor_status_chk (
  // clock, reset, register access
  input wire       core_clk_i,
  input wire       nrst_i,
  input wire [7:0] reg_addr_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  // live status
  input wire [3:0] input_selected_i,
  input wire [3:0] signal_loss_alarm_i,
  input wire       reference_signal_loss_i,
  input wire [3:0] frequency_offset_alarm_i,
  input wire       pll_unlocked_i,
  input wire       align_alarm_i,
  input wire       holdover_filter_valid_i,
  input wire       coarse_skew_busy_i,
  // outputs
  input wire [2:0] input1_band_select_o,
  input wire [2:0] input2_band_select_o,
  input wire [2:0] input3_band_select_o,
  input wire [2:0] input4_band_select_o,
  input wire       irq_o
);
  wire  [16:0] st = {coarse_skew_busy_i, holdover_filter_valid_i, align_alarm_i,
    frequency_offset_alarm_i, pll_unlocked_i, signal_loss_alarm_i,
    reference_signal_loss_i, input_selected_i};
  wire  [11:0] bands = {input4_band_select_o, input3_band_select_o,
    input2_band_select_o, input1_band_select_o};
  reg   [16:0] st1_r, st2_r, st3_r;
  // status as seen by a read, two sync stages plus the read edge
  always @(posedge core_clk_i) begin
    st1_r <= st;
    st2_r <= st1_r;
    st3_r <= st2_r;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
  sequence s_wr(a); reg_wr_i && reg_addr_i == a; endsequence
  a_active_read: assert property (
    s_rd(8'h80) |=> reg_rdata_o == {4'h0, st3_r[3:0] & ~st3_r[8:5]})
    else $error("active input read wrong");
  a_loss_read: assert property (
    s_rd(8'h81) |=> reg_rdata_o == {3'h0, st3_r[8:4]}) else $error("loss read wrong");
  a_alarm_read: assert property (
    s_rd(8'h82) |=> reg_rdata_o == st3_r[16:9]) else $error("alarm read wrong");
  a_range_a_write: assert property (
    s_wr(8'h37) |=> bands[5:0] == ($past(reg_wdata_i) & 8'h3f)) else $error("range a");
  a_range_b_write: assert property (
    s_wr(8'h38) |=> bands[11:6] == ($past(reg_wdata_i) & 8'h3f)) else $error("range b");
  a_band_hold: assert property (
    !(reg_wr_i && (reg_addr_i == 8'h37 || reg_addr_i == 8'h38)) |=> $stable(bands))
    else $error("band select changed without write");
  a_range_read: assert property (
    s_rd(8'h37) |=> reg_rdata_o == {2'h0, $past(input2_band_select_o),
    $past(input1_band_select_o)}) else $error("range a read wrong");
  a_unmapped_read: assert property (
    reg_rd_i && reg_addr_i > 8'h87 |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
endmodule // cim_monitor_status_chk
bind cim_monitor_status cim_monitor_status_chk u_chk (
  .core_clk_i               (core_clk_i),
  .nrst_i                   (nrst_i),
  .reg_addr_i               (reg_addr_i),
  .reg_wr_i                 (reg_wr_i),
  .reg_wdata_i              (reg_wdata_i),
  .reg_rd_i                 (reg_rd_i),
  .reg_rdata_o              (reg_rdata_o),
  .input_selected_i         (input_selected_i),
  .signal_loss_alarm_i      (signal_loss_alarm_i),
  .reference_signal_loss_i  (reference_signal_loss_i),
  .frequency_offset_alarm_i (frequency_offset_alarm_i),
  .pll_unlocked_i           (pll_unlocked_i),
  .align_alarm_i            (align_alarm_i),
  .holdover_filter_valid_i  (holdover_filter_valid_i),
  .coarse_skew_busy_i       (coarse_skew_busy_i),
  .input1_band_select_o     (input1_band_select_o),
  .input2_band_select_o     (input2_band_select_o),
  .input3_band_select_o     (input3_band_select_o),
  .input4_band_select_o     (input4_band_select_o),
  .irq_o                    (irq_o)
);

// ===== tb/test_cim_monitor_status.sv
// self-checking bench for the clock monitor status bank
`timescale 1ns/10ps
module test_cim_monitor_status;
  logic        core_clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  logic [16:0] st = 17'h0;
  wire  [7:0]  reg_rdata_o;
  wire  [2:0]  input1_band_select_o, input2_band_select_o;
  wire  [2:0]  input3_band_select_o, input4_band_select_o;
  wire         irq_o;
  wire  [3:0]  input_selected_i = st[3:0], signal_loss_alarm_i = st[8:5];
  wire  [3:0]  frequency_offset_alarm_i = st[13:10];
  wire         reference_signal_loss_i = st[4], pll_unlocked_i = st[9];
  wire         align_alarm_i = st[14], holdover_filter_valid_i = st[15];
  wire         coarse_skew_busy_i = st[16];
  wire  [11:0] bands = {input4_band_select_o, input3_band_select_o,
    input2_band_select_o, input1_band_select_o};
  int          err_total = 0, total_checks = 0;
  // status pattern, register, expected read
  logic [32:0] rows [11] = '{
    {17'h10000, 8'h82, 8'h80}, {17'h08000, 8'h82, 8'h40}, {17'h04000, 8'h82, 8'h20},
    {17'h02800, 8'h82, 8'h14}, {17'h00200, 8'h82, 8'h01}, {17'h000b0, 8'h81, 8'h0b},
    {17'h000af, 8'h80, 8'h0a}, {17'h00004, 8'h80, 8'h04}, {17'h1ffff, 8'h82, 8'hff},
    {17'h1ffff, 8'h81, 8'h1f}, {17'h1ffff, 8'h80, 8'h00}};
  cim_monitor_status u_cim_monitor_status (
    .core_clk_i               (core_clk_i),
    .nrst_i                   (nrst_i),
    .reg_addr_i               (reg_addr_i),
    .reg_wr_i                 (reg_wr_i),
    .reg_wdata_i              (reg_wdata_i),
    .reg_rd_i                 (reg_rd_i),
    .reg_rdata_o              (reg_rdata_o),
    .input_selected_i         (input_selected_i),
    .signal_loss_alarm_i      (signal_loss_alarm_i),
    .reference_signal_loss_i  (reference_signal_loss_i),
    .frequency_offset_alarm_i (frequency_offset_alarm_i),
    .pll_unlocked_i           (pll_unlocked_i),
    .align_alarm_i            (align_alarm_i),
    .holdover_filter_valid_i  (holdover_filter_valid_i),
    .coarse_skew_busy_i       (coarse_skew_busy_i),
    .input1_band_select_o     (input1_band_select_o),
    .input2_band_select_o     (input2_band_select_o),
    .input3_band_select_o     (input3_band_select_o),
    .input4_band_select_o     (input4_band_select_o),
    .irq_o                    (irq_o)
  );
  always #5 core_clk_i = ~core_clk_i;
  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input [11:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task acc(input w, input [7:0] a, d);
    @(negedge core_clk_i);
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 0;
    reg_rd_i = 0;
  endtask
  task rd(input [7:0] a, exp);
    acc(0, a, 8'h00);
    chk(reg_rdata_o, exp);
  endtask
  // status change, then let it cross the synchroniser
  task put(input [16:0] v);
    @(negedge core_clk_i);
    st = v;
    repeat (3) @(negedge core_clk_i);
  endtask
  initial begin
    #20000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test;
  end
  initial begin
    repeat (10) @(negedge core_clk_i);
    chk(bands, 12'h000);
    chk({irq_o, reg_rdata_o}, 12'h000);
    nrst_i = 1;
    repeat (3) @(negedge core_clk_i);
    foreach (rows[i]) begin
      put(rows[i][32:16]);
      rd(rows[i][15:8], rows[i][7:0]);
    end
    for (int c = 0; c < 8; c++) begin
      acc(1, 8'h37, {2'b11, c[2:0], ~c[2:0]});
      acc(1, 8'h38, {2'b11, ~c[2:0], c[2:0]});
      chk(bands, {~c[2:0], c[2:0], c[2:0], ~c[2:0]});
      rd(8'h37, {2'b00, c[2:0], ~c[2:0]});
    end
    put(17'h0);
    for (int a = 8'h80; a < 8'h83; a++) begin
      acc(1, a[7:0], 8'hff);
      rd(a[7:0], 8'h00);
    end
    acc(1, 8'ha0, 8'h5a);
    rd(8'ha0, 8'h00);
    put(17'h00010);
    chk(irq_o, 0);
    acc(1, 8'h87, 8'h01);
    chk(irq_o, 0);
    acc(1, 8'h85, 8'h1e);
    chk(irq_o, 1);
    put(17'h0);
    acc(1, 8'h83, 8'h1f);
    chk(irq_o, 1);
    acc(1, 8'h83, 8'h00);
    chk(irq_o, 0);
    rd(8'h83, 8'h00);
    rd(8'h84, 8'h7e);
    put(17'h00010);
    chk(irq_o, 1);
    acc(1, 8'h83, 8'h00);
    chk(irq_o, 1);
    rd(8'h83, 8'h01);
    nrst_i = 0;
    @(negedge core_clk_i);
    chk(bands, 12'h000);
    chk({irq_o, reg_rdata_o}, 12'h000);
    nrst_i = 1;
    repeat (3) @(negedge core_clk_i);
    rd(8'h38, 8'h00);
    rd(8'h81, 8'h01);
    finish_test;
  end
endmodule // test_cim_monitor_status

// ===== verilog/cim_monitor_status.v
// input clock monitor range selects, live status, sticky flags and interrupt
//
// Summary of operation
// - band codes 0..5 select ranges, 6-7 reserved
// - range reg A: input2 bits5:3, input1 bits2:0
// - range reg B: input4 bits5:3, input3 bits2:0
// - active bit set only if selected, no loss
// - loss status bits 1..4 for inputs one..four
// - loss status bit 0 is reference loss
// - alarm bits 1..4 are frequency offset alarms
// - alarm bit 0 reads 1 while unlocked
// - alarm bit 5 is frame alignment alarm
// - alarm bit 6 shows holdover filter valid
// - alarm bit 7 shows coarse skew busy
// - sticky flags latch, cleared by writing 0
// - interrupt needs pin enable and unmasked flag
`timescale 1ns/10ps
`include "cim_regs.vh"
module cim_monitor_status (
  // clock and reset
  input  wire                   core_clk_i,
  input  wire                   nrst_i,
  // register access from the serial control port
  input  wire [`CIM_ADDR_W-1:0] reg_addr_i,
  input  wire                   reg_wr_i,
  input  wire [`CIM_DATA_W-1:0] reg_wdata_i,
  input  wire                   reg_rd_i,
  output wire [`CIM_DATA_W-1:0] reg_rdata_o,
  // live alarms from the monitoring circuits
  input  wire [3:0]             input_selected_i,
  input  wire [3:0]             signal_loss_alarm_i,
  input  wire                   reference_signal_loss_i,
  input  wire [3:0]             frequency_offset_alarm_i,
  input  wire                   pll_unlocked_i,
  input  wire                   align_alarm_i,
  input  wire                   holdover_filter_valid_i,
  input  wire                   coarse_skew_busy_i,
  // band selects to the offset monitors
  output wire [2:0]             input1_band_select_o,
  output wire [2:0]             input2_band_select_o,
  output wire [2:0]             input3_band_select_o,
  output wire [2:0]             input4_band_select_o,
  // interrupt
  output wire                   irq_o
);
  reg                    rst_meta_r;
  reg                    rst_n_r;
  reg  [5:0]             range_a_r;
  reg  [5:0]             range_b_r;
  reg  [4:0]             loss_flg_r;
  reg  [4:0]             loss_flg_nxt;
  reg  [5:0]             alarm_flg_r;
  reg  [5:0]             alarm_flg_nxt;
  reg  [4:0]             loss_msk_r;
  reg  [5:0]             alarm_msk_r;
  reg                    int_en_r;
  reg  [`CIM_DATA_W-1:0] rdata_r;
  reg  [`CIM_DATA_W-1:0] rdata_nxt;
  wire [`CIM_SYNC_W-1:0] live_async;
  wire [`CIM_SYNC_W-1:0] live;
  wire [3:0]             sel_s;
  wire [4:0]             loss_s;
  wire [3:0]             fos_s;
  wire                   lol_s;
  wire                   align_s;
  wire                   hold_s;
  wire                   skew_s;
  wire [7:0]             active_reg;
  wire [7:0]             loss_reg;
  wire [7:0]             alarm_reg;
  wire [5:0]             alarm_evt;
  wire                   loss_pend;
  wire                   alarm_pend;

  // write strobe for one offset
  function wr_hit;
    input [`CIM_ADDR_W-1:0] addr;
    input [`CIM_ADDR_W-1:0] off;
    input                   wr;
    begin
      wr_hit = wr && (addr == off);
    end
  endfunction

  // reset release through two flops
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  assign live_async = {coarse_skew_busy_i, holdover_filter_valid_i, align_alarm_i,
                       pll_unlocked_i, frequency_offset_alarm_i,
                       signal_loss_alarm_i, reference_signal_loss_i, input_selected_i};

  cim_sync2 #(
    .W (`CIM_SYNC_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_r),
    .async_i    (live_async),
    .sync_o     (live)
  );

  assign sel_s   = live[3:0];
  assign loss_s  = live[8:4];
  assign fos_s   = live[12:9];
  assign lol_s   = live[13];
  assign align_s = live[14];
  assign hold_s  = live[15];
  assign skew_s  = live[16];

  assign active_reg = {4'h0, sel_s & ~loss_s[4:1]};
  assign loss_reg   = {3'h0, loss_s[4:1], loss_s[0]};
  assign alarm_reg  = {skew_s, hold_s, align_s, fos_s, lol_s};

  // alarm flag layout: align at 5, offsets 4:1, unlock at 0 (register bits 6:1)
  assign alarm_evt = {align_s, fos_s, lol_s};

  // band selects; reserved codes are stored as written
  assign input1_band_select_o = range_a_r[`CIM_RANGE_LO_MSB:`CIM_RANGE_LO_LSB];
  assign input2_band_select_o = range_a_r[`CIM_RANGE_HI_MSB:`CIM_RANGE_HI_LSB];
  assign input3_band_select_o = range_b_r[`CIM_RANGE_LO_MSB:`CIM_RANGE_LO_LSB];
  assign input4_band_select_o = range_b_r[`CIM_RANGE_HI_MSB:`CIM_RANGE_HI_LSB];

  // sticky flags: a write of 0 clears, a live event in the same cycle wins
  always @* begin
    loss_flg_nxt  = loss_flg_r;
    alarm_flg_nxt = alarm_flg_r;
    if (wr_hit(reg_addr_i, `CIM_OFF_LOSS_FLG, reg_wr_i)) begin
      loss_flg_nxt = loss_flg_r & reg_wdata_i[4:0];
    end
    if (wr_hit(reg_addr_i, `CIM_OFF_ALARM_FLG, reg_wr_i)) begin
      alarm_flg_nxt = alarm_flg_r & reg_wdata_i[6:1];
    end
    loss_flg_nxt  = loss_flg_nxt | loss_s;
    alarm_flg_nxt = alarm_flg_nxt | alarm_evt;
  end

  // range, flag, mask and pin enable registers
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      range_a_r   <= {`CIM_RANGE_RST, `CIM_RANGE_RST};
      range_b_r   <= {`CIM_RANGE_RST, `CIM_RANGE_RST};
      loss_flg_r  <= 5'h00;
      alarm_flg_r <= 6'h00;
      loss_msk_r  <= `CIM_LOSS_MSK_RST;
      alarm_msk_r <= `CIM_ALARM_MSK_RST;
      int_en_r    <= 1'b0;
    end else begin
      loss_flg_r  <= loss_flg_nxt;
      alarm_flg_r <= alarm_flg_nxt;
      if (wr_hit(reg_addr_i, `CIM_OFF_RANGE_A, reg_wr_i)) begin
        range_a_r <= reg_wdata_i[5:0];
      end
      if (wr_hit(reg_addr_i, `CIM_OFF_RANGE_B, reg_wr_i)) begin
        range_b_r <= reg_wdata_i[5:0];
      end
      if (wr_hit(reg_addr_i, `CIM_OFF_LOSS_MSK, reg_wr_i)) begin
        loss_msk_r <= reg_wdata_i[4:0];
      end
      if (wr_hit(reg_addr_i, `CIM_OFF_ALARM_MSK, reg_wr_i)) begin
        alarm_msk_r <= reg_wdata_i[6:1];
      end
      if (wr_hit(reg_addr_i, `CIM_OFF_INT_CTRL, reg_wr_i)) begin
        int_en_r <= reg_wdata_i[`CIM_INT_EN_BIT];
      end
    end
  end

  // mask bit 1 blocks its flag; the pin enable gates both groups
  assign loss_pend  = |(loss_flg_r & ~loss_msk_r);
  assign alarm_pend = |(alarm_flg_r & ~alarm_msk_r);
  assign irq_o      = int_en_r && (loss_pend || alarm_pend);

  // read mux; status offsets have no write path
  always @* begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      if (reg_addr_i == `CIM_OFF_RANGE_A) begin
        rdata_nxt = {2'h0, range_a_r};
      end else if (reg_addr_i == `CIM_OFF_RANGE_B) begin
        rdata_nxt = {2'h0, range_b_r};
      end else if (reg_addr_i == `CIM_OFF_ACTIVE) begin
        rdata_nxt = active_reg;
      end else if (reg_addr_i == `CIM_OFF_LOSS) begin
        rdata_nxt = loss_reg;
      end else if (reg_addr_i == `CIM_OFF_ALARM) begin
        rdata_nxt = alarm_reg;
      end else if (reg_addr_i == `CIM_OFF_LOSS_FLG) begin
        rdata_nxt = {3'h0, loss_flg_r};
      end else if (reg_addr_i == `CIM_OFF_ALARM_FLG) begin
        rdata_nxt = {1'b0, alarm_flg_r, 1'b0};
      end else if (reg_addr_i == `CIM_OFF_LOSS_MSK) begin
        rdata_nxt = {3'h0, loss_msk_r};
      end else if (reg_addr_i == `CIM_OFF_ALARM_MSK) begin
        rdata_nxt = {1'b0, alarm_msk_r, 1'b0};
      end else if (reg_addr_i == `CIM_OFF_INT_CTRL) begin
        rdata_nxt = {7'h00, int_en_r};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
endmodule // cim_monitor_status

// ===== verilog/cim_regs.vh
// register offsets, field positions and reset values of the clock monitor status bank
`ifndef CIM_REGS_VH
`define CIM_REGS_VH
`define CIM_ADDR_W          8
`define CIM_DATA_W          8
`define CIM_OFF_RANGE_A     8'h37
`define CIM_OFF_RANGE_B     8'h38
`define CIM_OFF_ACTIVE      8'h80
`define CIM_OFF_LOSS        8'h81
`define CIM_OFF_ALARM       8'h82
`define CIM_OFF_LOSS_FLG    8'h83
`define CIM_OFF_ALARM_FLG   8'h84
`define CIM_OFF_LOSS_MSK    8'h85
`define CIM_OFF_ALARM_MSK   8'h86
`define CIM_OFF_INT_CTRL    8'h87
`define CIM_RANGE_LO_MSB    2
`define CIM_RANGE_LO_LSB    0
`define CIM_RANGE_HI_MSB    5
`define CIM_RANGE_HI_LSB    3
`define CIM_RANGE_RST       3'h0
`define CIM_BAND_10_27      3'h0
`define CIM_BAND_25_54      3'h1
`define CIM_BAND_50_105     3'h2
`define CIM_BAND_95_215     3'h3
`define CIM_BAND_190_435    3'h4
`define CIM_BAND_375_710    3'h5
`define CIM_BAND_RSVD6      3'h6
`define CIM_BAND_RSVD7      3'h7
`define CIM_ALM_LOL_BIT     0
`define CIM_ALM_FOS_LSB     1
`define CIM_ALM_ALIGN_BIT   5
`define CIM_ALM_HOLD_BIT    6
`define CIM_ALM_SKEW_BIT    7
`define CIM_FLG_LOL_BIT     1
`define CIM_FLG_FOS_LSB     2
`define CIM_FLG_ALIGN_BIT   6
`define CIM_INT_EN_BIT      0
`define CIM_MSK_RST         8'hff
`define CIM_LOSS_MSK_RST    5'h1f
`define CIM_ALARM_MSK_RST   6'h3f
`define CIM_SYNC_W          17
`endif

// ===== verilog/cim_sync2.v
// two-flop synchroniser for a vector of independent status levels
`timescale 1ns/10ps
module cim_sync2 #(
  parameter W = 17
) (
  // clock and reset
  input  wire         core_clk_i,
  input  wire         rst_n_i,
  // levels
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // cim_sync2
